// File: dv/sfsc_core_tb.sv
`timescale 1ns/1ps
module sfsc_core_tb;
  import sfsc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] idle = 4'h0;
  logic hsr = 1'b0;
  logic fsr = 1'b0;
  logic [1:0] pclr = 2'h0;
  logic key_wr = 1'b0;
  logic lock_wr = 1'b0;
  logic tbl_wr = 1'b0;
  logic cmd_wr = 1'b0;
  logic fetch = 1'b0;
  logic [31:0] key = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] lock_cmd = 2'h0;
  logic [5:0] waddr = 6'h0;
  logic [3:0] bseq = 4'h0;
  sfsc_cmd_t cmd = '0;
  logic busy, locked, unlocked, rd_valid, miso, miso_b;
  logic bsel = 1'b0;
  logic [7:0] rd_data, cmd_seen, cmd_seen_b;
  logic [23:0] addr_seen, addr_seen_b;
  int edges;
  int edges_b;
  sfsc_pins_t pa, pb;
  int error_cnt = 0;
  int check_count = 0;
  int nbytes = 0;
  int badbytes = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  // Slower serial clock keeps the link period at 120 ns
  sfsc_core #(.HALF_DIV(6)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus_a_line2_idle_level_i(idle[0]), .bus_a_line3_idle_level_i(idle[1]),
    .bus_b_line2_idle_level_i(idle[2]), .bus_b_line3_idle_level_i(idle[3]),
    .host_domain_soft_reset_i(hsr), .flash_domain_soft_reset_i(fsr),
    .pointer_clear_register_i(pclr), .key_wr_i(key_wr), .table_key_register_i(key),
    .lock_wr_i(lock_wr), .table_lock_control_register_i(lock_cmd),
    .table_locked_o(locked), .table_unlocked_o(unlocked), .tbl_wr_i(tbl_wr),
    .tbl_addr_i(waddr), .tbl_wdata_i(wdata), .host_cmd_wr_i(cmd_wr),
    .host_command_register_i(cmd), .flash_addr_i(32'h00123456), .bus_b_sel_i(bsel),
    .buf_fetch_i(fetch), .buffer_sequence_index_i(bseq), .busy_o(busy),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .bus_a_o(pa), .bus_b_o(pb),
    .bus_a_data_lines_i({pa.dout[3:2] ^ pa.oe_n[3:2], pa.oe_n[1] ? miso : pa.dout[1],
      pa.dout[0] ^ pa.oe_n[0]}),
    .bus_b_data_lines_i({pb.dout[3:2] ^ pb.oe_n[3:2], pb.oe_n[1] ? miso_b : pb.dout[1],
      pb.dout[0] ^ pb.oe_n[0]}));
  sfsc_flash_model flash (.pins_i(pa), .miso_o(miso), .cmd_o(cmd_seen),
    .addr_o(addr_seen), .edge_cnt_o(edges));
  sfsc_flash_model flash_b (.pins_i(pb), .miso_o(miso_b), .cmd_o(cmd_seen_b),
    .addr_o(addr_seen_b), .edge_cnt_o(edges_b));
  always @(negedge sys_clk_i) begin
    if (rd_valid === 1'b1) begin
      nbytes++;
      if (rd_data !== 8'hC5) badbytes++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk_i);
    s = 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic wr_tbl(input logic [5:0] a, input logic [31:0] d);
    waddr = a;
    wdata = d;
    pulse(tbl_wr);
  endtask
  // Key and lock write back to back, or with one idle cycle between
  task automatic lock_op(input logic [31:0] k, input logic [1:0] c, input bit gap);
    key = k;
    key_wr = 1'b1;
    @(negedge sys_clk_i);
    key_wr = 1'b0;
    if (gap) @(negedge sys_clk_i);
    lock_cmd = c;
    lock_wr = 1'b1;
    @(negedge sys_clk_i);
    lock_wr = 1'b0;
    @(negedge sys_clk_i);
  endtask
  // Frame on the bus that bsel selects; bus A edge count and byte count judged after it ends
  task automatic run(input logic bf, input logic [3:0] seq, input logic [15:0] size,
      input logic [1:0] clr, input int exp_edges, input int exp_bytes);
    int n;
    pclr = clr;
    @(negedge sys_clk_i);
    pclr = 2'h0;
    nbytes = 0;
    badbytes = 0;
    cmd = '{unused: 4'h0, sequence_index: seq, flags: 8'h0, host_data_size: size};
    bseq = seq;
    if (bf) pulse(fetch);
    else pulse(cmd_wr);
    chk(busy, 1);
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (3) @(negedge sys_clk_i);
    chk(edges, exp_edges);
    chk(nbytes, exp_bytes);
    chk(badbytes, 0);
    chk({busy, pa.cs_n}, 1);
  endtask
  task automatic t_idle();
    for (int i = 0; i < 16; i++) begin
      idle = i[3:0];
      repeat (2) @(negedge sys_clk_i);
      chk({pa.dout[3:2], pb.dout[3:2]}, {idle[1:0], idle[3:2]});
      chk({pa.oe_n[3:2], pb.oe_n[3:2]}, 0);
    end
  endtask
  task automatic t_default();
    chk({locked, unlocked}, 2);
    run(0, 4'h0, 16'h0, 2'h1, 288, 32);
    chk(cmd_seen, 8'h03);
    chk(addr_seen, 24'h123456);
    run(0, 4'h0, 16'h2, 2'h1, 48, 2);
  endtask
  task automatic t_lock();
    wr_tbl(6'h04, 32'h08180401);
    run(0, 4'h1, 16'h0, 2'h1, 0, 0);
    lock_op(32'h5AF05AF1, UNLOCK_CMD, 1'b0);
    chk(unlocked, 0);
    lock_op(KEY_VALUE, UNLOCK_CMD, 1'b0);
    chk({locked, unlocked}, 1);
    wr_tbl(6'h04, {INS_ADDR, 2'h0, 8'h18, INS_CMD, 2'h0, 8'h0B});
    wr_tbl(6'h05, {INS_READ, 2'h0, 8'h01, INS_DUMMY, 2'h0, 8'h08});
    wr_tbl(6'h06, {INS_STOP, 2'h0, 8'h00, INS_JUMP, 2'h0, 8'h02});
    cmd = '{unused: 4'h0, sequence_index: 4'h0, flags: 8'h0, host_data_size: 16'h0};
    pulse(cmd_wr);
    repeat (300) @(negedge sys_clk_i);
    hsr = 1'b1;
    fsr = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk({busy, pa.cs_n, unlocked}, 3);
    hsr = 1'b0;
    fsr = 1'b0;
    run(0, 4'h1, 16'h2, 2'h3, 56, 2);
    chk(cmd_seen, 8'h0B);
    lock_op(KEY_VALUE, LOCK_CMD, 1'b1);
    chk({locked, unlocked}, 2);
    wr_tbl(6'h04, 32'h0);
  endtask
  // Resume from a jump target unless the pointer is cleared
  task automatic t_ptr();
    run(0, 4'h1, 16'h2, 2'h1, 56, 2);
    run(0, 4'h1, 16'h2, 2'h0, 24, 2);
    run(0, 4'h1, 16'h2, 2'h1, 56, 2);
    run(1, 4'h1, 16'h0, 2'h2, 104, 8);
    run(1, 4'h1, 16'h0, 2'h0, 72, 8);
    run(1, 4'h1, 16'h0, 2'h2, 104, 8);
  endtask
  // Frame on bus B; the bus A model must see no frame at all
  task automatic t_bus_b();
    int a_edges;
    a_edges = edges;
    bsel = 1'b1;
    run(0, 4'h0, 16'h1, 2'h1, a_edges, 1);
    chk(edges_b, 40);
    chk(cmd_seen_b, 8'h03);
    chk(addr_seen_b, 24'h123456);
    chk(pb.cs_n, 1);
    bsel = 1'b0;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    t_default();
    t_idle();
    t_lock();
    t_ptr();
    t_bus_b();
    test_done();
  end
  initial begin
    #900000;
    error_cnt++;
    test_done();
  end
endmodule

// File: dv/sfsc_flash_model.sv
`timescale 1ns/1ps
// Single-line flash: captures command and address, streams one fixed byte
module sfsc_flash_model #(
  parameter logic [7:0] RD_BYTE = 8'hC5
) (
  input wire sfsc_pkg::sfsc_pins_t pins_i,
  output logic miso_o,
  output logic [7:0] cmd_o,
  output logic [23:0] addr_o,
  output int edge_cnt_o
);
  import sfsc_pkg::*;
  logic [31:0] shin = 32'h0;
  logic miso = 1'b0;
  int cnt = 0;
  assign miso_o = miso;
  assign cmd_o = shin[31:24];
  assign addr_o = shin[23:0];
  assign edge_cnt_o = cnt;
  // Select falls with the clock low, so a high clock marks a rising edge
  always @(posedge pins_i.sck or negedge pins_i.cs_n) begin
    if (!pins_i.sck) begin
      cnt = 0;
      shin = 32'h0;
    end else if (!pins_i.cs_n) begin
      if (cnt < 32) shin = {shin[30:0], pins_i.dout[0]};
      cnt = cnt + 1;
    end
  end
  // Aligned to multiples of 8 edges, so resumed sequences still line up
  // Released line must not keep showing the last bit
  always @(negedge pins_i.sck or posedge pins_i.cs_n) begin
    if (pins_i.cs_n) miso = ~miso;
    else miso = RD_BYTE[7 - (cnt % 8)];
  end
endmodule

// File: hw/sfsc_core.sv
`timescale 1ns/1ps
// Overview of operation
// - An inactive bus A drives data line 2 to its line-2 idle level.
// - An inactive bus A drives data line 3 to its line-3 idle level.
// - An inactive bus B drives data line 2 to its line-2 idle level.
// - An inactive bus B drives data line 3 to its line-3 idle level.
// - Host soft reset clears host-domain flops but keeps configuration.
// - Flash soft reset clears flash-domain flops but keeps configuration.
// - Pointer clear bits reset the host and buffer sequence pointers.
// - Key then 2 unlocks the table, key then 1 locks it, status shows it.
// - Codes 1, 2 and 3 send a command byte, address bits, dummy cycles.
// - Code 7 reads data and code 9 jumps to an index and ends the frame.
// - Pad value 0 carries the instruction on a single data line.
// - Sequence 0 holds a 32-byte read straight out of reset.
// - A host command starts its sequence; nonzero size overrides reads.
module sfsc_core #(
  parameter int HALF_DIV = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic bus_a_line2_idle_level_i,
  input wire logic bus_a_line3_idle_level_i,
  input wire logic bus_b_line2_idle_level_i,
  input wire logic bus_b_line3_idle_level_i,
  input wire logic host_domain_soft_reset_i,
  input wire logic flash_domain_soft_reset_i,
  input wire logic [1:0] pointer_clear_register_i,
  input wire logic key_wr_i,
  input wire logic [31:0] table_key_register_i,
  input wire logic lock_wr_i,
  input wire logic [1:0] table_lock_control_register_i,
  output logic table_locked_o,
  output logic table_unlocked_o,
  input wire logic tbl_wr_i,
  input wire logic [sfsc_pkg::TBL_AW-1:0] tbl_addr_i,
  input wire logic [31:0] tbl_wdata_i,
  input wire logic host_cmd_wr_i,
  input wire sfsc_pkg::sfsc_cmd_t host_command_register_i,
  input wire logic [31:0] flash_addr_i,
  input wire logic bus_b_sel_i,
  input wire logic buf_fetch_i,
  input wire logic [3:0] buffer_sequence_index_i,
  output logic busy_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output sfsc_pkg::sfsc_pins_t bus_a_o,
  output sfsc_pkg::sfsc_pins_t bus_b_o,
  input wire logic [3:0] bus_a_data_lines_i,
  input wire logic [3:0] bus_b_data_lines_i
);
  import sfsc_pkg::*;

  function automatic logic [1:0] lane_log(input logic [1:0] pad);
    return (pad == 2'h0) ? 2'h0 : (pad == 2'h1) ? 2'h1 : 2'h2;
  endfunction

  function automatic logic [19:0] ticks(input sfsc_instr_t i, input logic [15:0] ovr);
    logic [19:0] bits;
    bits = 20'h0;
    case (i.code)
      INS_CMD: bits = 20'h8;
      INS_ADDR: bits = {12'h0, i.oprnd};
      INS_READ: bits = (ovr != 16'h0) ? {1'b0, ovr, 3'h0}
                                      : ({9'h0, i.oprnd, 3'h0} << READ_SH);
      default: bits = 20'h0;
    endcase
    if (i.code == INS_DUMMY) begin
      return {12'h0, i.oprnd};
    end
    return bits >> lane_log(i.pad);
  endfunction

  function automatic sfsc_pins_t mk_pins(input logic act, input logic cs_on,
      input logic clk, input logic [1:0] idle, input logic [3:0] en,
      input logic [3:0] val, input logic quad);
    sfsc_pins_t p;
    p.cs_n = ~(act & cs_on);
    p.sck = act & clk;
    p.dout[1:0] = {2{act}} & en[1:0] & val[1:0];
    p.oe_n[1:0] = ~({2{act}} & en[1:0]);
    if (act && quad) begin
      p.dout[3:2] = en[3:2] & val[3:2];
      p.oe_n[3:2] = ~en[3:2];
    end else begin
      p.dout[3:2] = idle;
      p.oe_n[3:2] = 2'b00;
    end
    return p;
  endfunction

  logic [31:0] tbl [TBL_WORDS];
  logic locked;
  logic key_armed;
  logic [2:0] host_ptr;
  logic [2:0] buf_ptr;
  logic [7:0] sync1;
  logic [7:0] sync2;
  sfsc_eng_t eng;
  sfsc_eng_t next_eng;

  wire any_wr = key_wr_i | lock_wr_i | tbl_wr_i | host_cmd_wr_i;
  wire key_ok = key_wr_i & (table_key_register_i == KEY_VALUE);
  wire do_lock = lock_wr_i & key_armed & (table_lock_control_register_i == LOCK_CMD);
  wire do_unlock = lock_wr_i & key_armed & (table_lock_control_register_i == UNLOCK_CMD);
  wire idle = eng.state == ST_IDLE;
  wire host_go = host_cmd_wr_i & idle;
  wire buf_go = buf_fetch_i & ~host_cmd_wr_i & idle;
  wire [31:0] word = tbl[{eng.seq, eng.ptr[2:1]}];
  wire sfsc_instr_t fetched = eng.ptr[0] ? word[31:16] : word[15:0];
  wire [19:0] load_cnt = ticks(fetched, eng.size_ovr);
  wire running = eng.state == ST_RUN;
  wire wrap = eng.div == 16'(HALF_DIV - 1);
  wire rise = running & wrap & ~eng.sck;
  wire fall = running & wrap & eng.sck;
  wire last = fall & (eng.cnt == 20'h1);
  wire is_out = (eng.ins.code == INS_CMD) | (eng.ins.code == INS_ADDR);
  wire is_read = eng.ins.code == INS_READ;
  wire [2:0] lanes = 3'h1 << lane_log(eng.ins.pad);
  wire [3:0] din = eng.bus_b ? sync2[7:4] : sync2[3:0];
  wire [3:0] rb_next = eng.rbits + {1'b0, lanes};
  wire byte_done = rb_next == 4'h8;
  wire [7:0] rd_next = (eng.ins.pad == 2'h0) ? {eng.rdsh[6:0], din[1]} :
                       (eng.ins.pad == 2'h1) ? {eng.rdsh[5:0], din[1:0]} :
                       {eng.rdsh[3:0], din};
  wire [3:0] use_mask = (eng.ins.pad == 2'h0) ? 4'h1 :
                        (eng.ins.pad == 2'h1) ? 4'h3 : 4'hF;
  wire [3:0] drv_en = (running & is_out) ? use_mask : 4'h0;
  wire [3:0] drv_val = (eng.ins.pad == 2'h0) ? {3'h0, eng.shreg[31]} :
                       (eng.ins.pad == 2'h1) ? {2'h0, eng.shreg[31:30]} :
                       eng.shreg[31:28];
  wire quad_act = running & eng.ins.pad[1];
  wire cs_on = (eng.state == ST_LOAD) | running;
  wire end_wb = eng.state == ST_END;
  wire [2:0] ptr_inc = eng.ptr + 3'h1;
  wire [2:0] next_host_ptr = pointer_clear_register_i[PCLR_HOST] ? 3'h0 :
                             (end_wb & ~eng.from_buf) ? eng.ptr : host_ptr;
  wire [2:0] next_buf_ptr = pointer_clear_register_i[PCLR_BUF] ? 3'h0 :
                            (end_wb & eng.from_buf) ? eng.ptr : buf_ptr;
  wire sfsc_pins_t next_a = mk_pins(~eng.bus_b & ~idle, cs_on, eng.sck,
      {bus_a_line3_idle_level_i, bus_a_line2_idle_level_i}, drv_en, drv_val, quad_act);
  wire sfsc_pins_t next_b = mk_pins(eng.bus_b & ~idle, cs_on, eng.sck,
      {bus_b_line3_idle_level_i, bus_b_line2_idle_level_i}, drv_en, drv_val, quad_act);

  assign table_locked_o = locked;
  assign table_unlocked_o = ~locked;
  assign busy_o = ~idle;

  always_comb begin
    next_eng = eng;
    unique case (eng.state)
      ST_IDLE: begin
        if (host_go || buf_go) begin
          next_eng.state = ST_LOAD;
          next_eng.bus_b = bus_b_sel_i;
          next_eng.from_buf = buf_go;
          next_eng.seq = buf_go ? buffer_sequence_index_i
                                : host_command_register_i.sequence_index;
          next_eng.ptr = buf_go ? buf_ptr : host_ptr;
          next_eng.size_ovr = buf_go ? 16'h0 : host_command_register_i.host_data_size;
          next_eng.addr = flash_addr_i;
        end
      end
      ST_LOAD: begin
        next_eng.ins = fetched;
        next_eng.cnt = load_cnt;
        next_eng.div = 16'h0;
        next_eng.sck = 1'b0;
        next_eng.rbits = 4'h0;
        next_eng.shreg = (fetched.code == INS_CMD) ? {fetched.oprnd, 24'h0} :
                         eng.addr << (6'd32 - fetched.oprnd[5:0]);
        if (fetched.code == INS_JUMP) begin
          next_eng.ptr = fetched.oprnd[2:0];
          next_eng.state = ST_END;
        end else if (fetched.code == INS_STOP) begin
          next_eng.ptr = 3'h0;
          next_eng.state = ST_END;
        end else if (load_cnt == 20'h0) begin
          next_eng.ptr = ptr_inc;
          next_eng.state = (eng.ptr == 3'h7) ? ST_END : ST_LOAD;
        end else begin
          next_eng.state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_eng.div = wrap ? 16'h0 : eng.div + 16'h1;
        next_eng.sck = wrap ? ~eng.sck : eng.sck;
        if (rise && is_read) begin
          next_eng.rdsh = rd_next;
          next_eng.rbits = byte_done ? 4'h0 : rb_next;
        end
        if (fall) begin
          next_eng.shreg = eng.shreg << lanes;
          next_eng.cnt = eng.cnt - 20'h1;
        end
        if (last) begin
          next_eng.ptr = ptr_inc;
          next_eng.state = (eng.ptr == 3'h7) ? ST_END : ST_LOAD;
        end
      end
      ST_END: next_eng.state = ST_IDLE;
    endcase
  end

  // Flash domain: engine, pins and input synchronisers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      eng <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      bus_a_o <= sfsc_pins_t'(PINS_RST);
      bus_b_o <= sfsc_pins_t'(PINS_RST);
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else if (flash_domain_soft_reset_i) begin
      eng <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      bus_a_o <= sfsc_pins_t'(PINS_RST);
      bus_b_o <= sfsc_pins_t'(PINS_RST);
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      eng <= next_eng;
      rd_valid_o <= rise & is_read & byte_done;
      rd_data_o <= (rise & is_read & byte_done) ? rd_next : rd_data_o;
      bus_a_o <= next_a;
      bus_b_o <= next_b;
      sync1 <= {bus_b_data_lines_i, bus_a_data_lines_i};
      sync2 <= sync1;
    end
  end

  // Host domain; key arming dies on any other write in between
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_ptr <= 3'h0;
      buf_ptr <= 3'h0;
      key_armed <= 1'b0;
    end else if (host_domain_soft_reset_i) begin
      host_ptr <= 3'h0;
      buf_ptr <= 3'h0;
      key_armed <= 1'b0;
    end else begin
      host_ptr <= next_host_ptr;
      buf_ptr <= next_buf_ptr;
      key_armed <= key_ok | (key_armed & ~any_wr);
    end
  end

  // Configuration: only the hard reset touches it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked <= 1'b1;
      for (int k = 0; k < TBL_WORDS; k++) begin
        tbl[k] <= (k == 0) ? RST_WORD0 : (k == 1) ? RST_WORD1 : 32'h0;
      end
    end else begin
      locked <= do_lock | (locked & ~do_unlock);
      if (tbl_wr_i && !locked) begin
        tbl[tbl_addr_i] <= tbl_wdata_i;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  wire [31:0] tbl_sel = tbl[tbl_addr_i];
  wire q_flash = ~flash_domain_soft_reset_i;

  a_idle_a_line2: assert property ((q_flash && (idle || eng.bus_b)) |=>
    (bus_a_o.dout[2] == $past(bus_a_line2_idle_level_i) && !bus_a_o.oe_n[2]))
    else $error("bus A line 2 idle level wrong");
  a_idle_a_line3: assert property ((q_flash && (idle || eng.bus_b)) |=>
    (bus_a_o.dout[3] == $past(bus_a_line3_idle_level_i) && !bus_a_o.oe_n[3]))
    else $error("bus A line 3 idle level wrong");
  a_idle_b_line2: assert property ((q_flash && (idle || !eng.bus_b)) |=>
    (bus_b_o.dout[2] == $past(bus_b_line2_idle_level_i) && !bus_b_o.oe_n[2]))
    else $error("bus B line 2 idle level wrong");
  a_idle_b_line3: assert property ((q_flash && (idle || !eng.bus_b)) |=>
    (bus_b_o.dout[3] == $past(bus_b_line3_idle_level_i) && !bus_b_o.oe_n[3]))
    else $error("bus B line 3 idle level wrong");
  a_host_rst_clear: assert property (host_domain_soft_reset_i |=>
    (host_ptr == 3'h0 && buf_ptr == 3'h0 && locked == $past(locked)))
    else $error("host soft reset misbehaved");
  a_flash_rst_clear: assert property (flash_domain_soft_reset_i |=>
    (idle && !rd_valid_o && bus_a_o.cs_n && locked == $past(locked)))
    else $error("flash soft reset misbehaved");
  a_ptr_clear_host: assert property ((pointer_clear_register_i[PCLR_HOST]) |=>
    (host_ptr == 3'h0))
    else $error("host pointer not cleared");
  a_unlock_seq: assert property ((key_ok && !host_domain_soft_reset_i) ##1
    (lock_wr_i && table_lock_control_register_i == UNLOCK_CMD) |=> table_unlocked_o)
    else $error("unlock sequence failed");
  a_cmd_decode: assert property ((eng.state == ST_LOAD && fetched.code == INS_CMD &&
    q_flash) |=> (running && eng.cnt == (20'h8 >> lane_log(eng.ins.pad))))
    else $error("command instruction count wrong");
  a_jump_ptr: assert property ((eng.state == ST_LOAD && fetched.code == INS_JUMP &&
    q_flash) |=> (end_wb && eng.ptr == $past(fetched.oprnd[2:0])) ##1 idle)
    else $error("jump did not end the frame");
  a_single_line: assert property ((running && is_out && eng.ins.pad == 2'h0 &&
    !eng.bus_b && q_flash) |=> (bus_a_o.oe_n[1:0] == 2'b10))
    else $error("single pad uses extra lines");
  a_reset_table: assert property ($fell(rst_i) |->
    (tbl[0] == RST_WORD0 && tbl[1] == RST_WORD1))
    else $error("reset sequence missing");
  a_size_override: assert property ((eng.state == ST_LOAD && fetched.code == INS_READ &&
    eng.size_ovr != 16'h0 && q_flash) |=>
    (eng.cnt == ({1'b0, eng.size_ovr, 3'h0} >> lane_log(eng.ins.pad))))
    else $error("data size override ignored");
  a_start_seq: assert property ((host_go && q_flash) |=>
    (eng.state == ST_LOAD && eng.seq == $past(host_command_register_i.sequence_index)))
    else $error("host command did not start");
  a_locked_ignore: assert property ((tbl_wr_i && table_locked_o) |=>
    (tbl[$past(tbl_addr_i)] == $past(tbl_sel)))
    else $error("locked table was written");

  c_read_byte: cover property (rd_valid_o);
  c_jump_end: cover property (eng.state == ST_LOAD && fetched.code == INS_JUMP);
  c_unlock: cover property (do_unlock);
  c_buf_fetch: cover property (buf_go);
endmodule

// File: hw/sfsc_pkg.sv
package sfsc_pkg;
  localparam logic [31:0] KEY_VALUE = 32'h5AF05AF0;
  localparam logic [1:0] LOCK_CMD = 2'h1;
  localparam logic [1:0] UNLOCK_CMD = 2'h2;
  localparam logic [5:0] INS_STOP = 6'h00;
  localparam logic [5:0] INS_CMD = 6'h01;
  localparam logic [5:0] INS_ADDR = 6'h02;
  localparam logic [5:0] INS_DUMMY = 6'h03;
  localparam logic [5:0] INS_READ = 6'h07;
  localparam logic [5:0] INS_JUMP = 6'h09;
  localparam int TBL_WORDS = 64;
  localparam int TBL_AW = 6;
  localparam int READ_SH = 3;
  localparam int PCLR_HOST = 0;
  localparam int PCLR_BUF = 1;
  localparam logic [31:0] RST_WORD0 = 32'h08180403;
  localparam logic [31:0] RST_WORD1 = 32'h24001C04;
  localparam logic [9:0] PINS_RST = 10'h20F;

  typedef struct packed {
    logic [5:0] code;
    logic [1:0] pad;
    logic [7:0] oprnd;
  } sfsc_instr_t;

  typedef struct packed {
    logic [3:0] unused;
    logic [3:0] sequence_index;
    logic [7:0] flags;
    logic [15:0] host_data_size;
  } sfsc_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] dout;
    logic [3:0] oe_n;
  } sfsc_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11,
    ST_END = 2'b10
  } sfsc_state_t;

  typedef struct packed {
    sfsc_state_t state;
    logic bus_b;
    logic from_buf;
    logic [3:0] seq;
    logic [2:0] ptr;
    logic [15:0] size_ovr;
    logic [31:0] addr;
    sfsc_instr_t ins;
    logic [19:0] cnt;
    logic [31:0] shreg;
    logic [7:0] rdsh;
    logic [3:0] rbits;
    logic [15:0] div;
    logic sck;
  } sfsc_eng_t;
endpackage
